// ==== hw/dasr_pkg.sv ====
package dasr_pkg;
  // Register offsets on the debug link's access-layer address space
  localparam logic [3:0] KEY_STATUS_OFS = 4'h7;
  localparam logic [3:0] RESET_REQ_OFS = 4'h8;
  localparam logic [3:0] CLK_CTRL_OFS = 4'h9;
  localparam logic [3:0] SYS_CTRL_OFS = 4'hA;
  localparam logic [3:0] SYS_STATUS_OFS = 4'hB;
  localparam logic [3:0] CRC_STATUS_OFS = 4'hC;
  // Field positions
  localparam int KEY_UROW_BIT = 5;
  localparam int KEY_NVM_BIT = 4;
  localparam int KEY_ERASE_BIT = 3;
  localparam int CTRL_UROW_DONE_BIT = 1;
  localparam int CTRL_SYSTEM_CLOCK_REQUEST_BIT = 0;
  localparam int ST_RST_BIT = 5;
  localparam int ST_SLEEP_BIT = 4;
  localparam int ST_NVM_BIT = 3;
  localparam int ST_UROW_BIT = 2;
  localparam int ST_LOCK_BIT = 0;
  // Values
  localparam logic [7:0] RESET_SIGNATURE = 8'h59;
  localparam logic [1:0] CLK_SEL_RESET = 2'h3;
  localparam logic [7:0] SYS_STATUS_RESET = 8'h01;
  localparam logic [2:0] CRC_OFF = 3'h0;
  localparam logic [2:0] CRC_BUSY = 3'h1;
  localparam logic [2:0] CRC_PASS = 3'h2;
  localparam logic [2:0] CRC_FAIL = 3'h4;
  // Link clock selections
  localparam logic [1:0] CLK_SEL_32M = 2'h0;
  localparam logic [1:0] CLK_SEL_16M = 2'h1;
  localparam logic [1:0] CLK_SEL_8M = 2'h2;
  localparam logic [1:0] CLK_SEL_4M = 2'h3;
  // Clock enable divider per selection, 32 MHz base
  localparam logic [3:0] DIV_32M = 4'h1;
  localparam logic [3:0] DIV_16M = 4'h2;
  localparam logic [3:0] DIV_8M = 4'h4;
  localparam logic [3:0] DIV_4M = 4'h8;
  localparam int SYNC_STAGES = 3;
endpackage

// ==== hw/dasr_sync.sv ====
`timescale 1ns/1ns
// Three-stage synchroniser; output changes once stages two and three agree
module dasr_sync (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic rst_val_i,
  // Data
  input wire logic async_i,
  output logic sync_o
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic val_ff;
  logic [1:0] prime_ff;
  logic primed;

  assign primed = (prime_ff == 2'(dasr_pkg::SYNC_STAGES));

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Reset value stands until every stage holds a real sample, so no false level
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prime_ff <= 2'h0;
    end else if (!primed) begin
      prime_ff <= prime_ff + 2'h1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      val_ff <= 1'b0;
    end else if (!primed) begin
      val_ff <= rst_val_i;
    end else if (s2_ff == s3_ff) begin
      val_ff <= s3_ff;
    end
  end

  assign sync_o = primed ? val_ff : rst_val_i;
endmodule // dasr_sync

// ==== hw/dasr_regs.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// - Key status bit 5 reads 1 while user-row write key active.
// - Key status bit 4 shows programming key; clears when programming ends.
// - Key status bit 3 shows full-erase key; clears when erase completes.
// - Writing 0x59 to reset request asserts and holds system reset.
// - Any other value written releases the held system reset.
// - Reset request reads bit 0 as held-reset state, other bits zero.
// - System reset from this register never resets the debug logic.
// - Clock select 0..3 gives 32/16/8/4 MHz; 4 MHz after reset/enable.
// - Writing 1 to control bit 1 starts user-row flash programming.
// - Programming-done bit writable only after user-row key decoded.
// - Control bit 0 requests system clock regardless of sleep; 0 withdraws.
// - Clock request bit set on interface enable, cleared on disable.
// - Status bit 5 flags system reset, including held; read clears it.
// - Status bit 4 reads 1 while system idle or deeper sleep.
// - Status bit 3 allows memory programming; debugger then resets system.
// - Status bit 2 allows user-row programming; debugger then sets done.
// - Status bit 0 reads 1 while locked, 0 after full erase.
// - CRC status one-hot: 0 off, 1 busy, 2 pass, 4 fail.
// - Registers reached only from the debug link, not the processor.
module dasr_regs (
  // Clock and reset of the debug logic only
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Interface enable from the physical layer
  input wire logic link_enable_i,
  // Access-layer register port, driven only by the debug link
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Key decode events from the link
  input wire logic user_row_key_set_i,
  input wire logic mem_prog_key_set_i,
  input wire logic erase_key_set_i,
  // System-domain status, asynchronous to this clock
  input wire logic sys_in_reset_i,
  input wire logic sys_asleep_i,
  input wire logic mem_prog_ready_i,
  input wire logic user_row_ready_i,
  input wire logic lock_bits_set_i,
  input wire logic mem_prog_done_i,
  input wire logic erase_done_i,
  input wire logic crc_enabled_i,
  input wire logic crc_busy_i,
  input wire logic crc_pass_i,
  // System-domain controls
  output logic system_reset_o,
  output logic system_clock_request_o,
  output logic user_row_programming_start_o,
  output logic [1:0] link_clock_select_o,
  output logic link_clock_tick_o
);
  logic user_row_write_key_active_ff;
  logic memory_programming_key_active_ff;
  logic full_erase_key_active_ff;
  logic system_reset_signature_ff;
  logic [1:0] link_clock_select_ff;
  logic system_clock_request_ff;
  logic urow_start_ff;
  logic system_reset_active_ff;
  logic [7:0] rdata_ff;
  logic [3:0] div_cnt_ff;
  logic tick_ff;
  logic enable_d_ff;
  logic [3:0] nxt_div_lim;
  logic [7:0] nxt_rdata;
  logic [2:0] nxt_crc;

  logic in_reset_s;
  logic asleep_s;
  logic prog_ready_s;
  logic urow_ready_s;
  logic locked_s;
  logic prog_done_s;
  logic erase_done_s;
  logic crc_en_s;
  logic crc_busy_s;
  logic crc_pass_s;

  logic wr_key;
  logic wr_rst;
  logic wr_clk;
  logic wr_ctl;
  logic rd_stat;
  logic enable_rise;

  dasr_sync u_sync_in_reset (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .rst_val_i(1'b0),
    .async_i(sys_in_reset_i),
    .sync_o(in_reset_s)
  );
  dasr_sync u_sync_asleep (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .rst_val_i(1'b0),
    .async_i(sys_asleep_i),
    .sync_o(asleep_s)
  );
  dasr_sync u_sync_prog_ready (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .rst_val_i(1'b0),
    .async_i(mem_prog_ready_i),
    .sync_o(prog_ready_s)
  );
  dasr_sync u_sync_urow_ready (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .rst_val_i(1'b0),
    .async_i(user_row_ready_i),
    .sync_o(urow_ready_s)
  );
  // Lock sync starts locked so status never shows unlocked before sampling
  dasr_sync u_sync_locked (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .rst_val_i(1'b1),
    .async_i(lock_bits_set_i),
    .sync_o(locked_s)
  );
  dasr_sync u_sync_prog_done (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .rst_val_i(1'b0),
    .async_i(mem_prog_done_i),
    .sync_o(prog_done_s)
  );
  dasr_sync u_sync_erase_done (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .rst_val_i(1'b0),
    .async_i(erase_done_i),
    .sync_o(erase_done_s)
  );
  dasr_sync u_sync_crc_en (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .rst_val_i(1'b0),
    .async_i(crc_enabled_i),
    .sync_o(crc_en_s)
  );
  dasr_sync u_sync_crc_busy (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .rst_val_i(1'b0),
    .async_i(crc_busy_i),
    .sync_o(crc_busy_s)
  );
  dasr_sync u_sync_crc_pass (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .rst_val_i(1'b0),
    .async_i(crc_pass_i),
    .sync_o(crc_pass_s)
  );

  // Only the debug link drives this port; no processor path exists
  assign wr_key = reg_wr_i && (reg_addr_i == dasr_pkg::KEY_STATUS_OFS);
  assign wr_rst = reg_wr_i && (reg_addr_i == dasr_pkg::RESET_REQ_OFS);
  assign wr_clk = reg_wr_i && (reg_addr_i == dasr_pkg::CLK_CTRL_OFS);
  assign wr_ctl = reg_wr_i && (reg_addr_i == dasr_pkg::SYS_CTRL_OFS);
  assign rd_stat = reg_rd_i && (reg_addr_i == dasr_pkg::SYS_STATUS_OFS);
  assign enable_rise = link_enable_i && !enable_d_ff;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      enable_d_ff <= 1'b0;
    end else begin
      enable_d_ff <= link_enable_i;
    end
  end

  // Keys; writing the user-row bit ends the session, so a write clears it
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      user_row_write_key_active_ff <= 1'b0;
      memory_programming_key_active_ff <= 1'b0;
      full_erase_key_active_ff <= 1'b0;
    end else if (!link_enable_i) begin
      user_row_write_key_active_ff <= 1'b0;
      memory_programming_key_active_ff <= 1'b0;
      full_erase_key_active_ff <= 1'b0;
    end else begin
      if (user_row_key_set_i) begin
        user_row_write_key_active_ff <= 1'b1;
      end else if (wr_key && reg_wdata_i[dasr_pkg::KEY_UROW_BIT]) begin
        user_row_write_key_active_ff <= 1'b0;
      end
      if (mem_prog_key_set_i) begin
        memory_programming_key_active_ff <= 1'b1;
      end else if (prog_done_s) begin
        memory_programming_key_active_ff <= 1'b0;
      end
      if (erase_key_set_i) begin
        full_erase_key_active_ff <= 1'b1;
      end else if (erase_done_s) begin
        full_erase_key_active_ff <= 1'b0;
      end
    end
  end

  // Held system reset; cleared by any non-0x59 write, by link disable or by reset, not by itself
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      system_reset_signature_ff <= 1'b0;
    end else if (!link_enable_i) begin
      system_reset_signature_ff <= 1'b0;
    end else if (wr_rst) begin
      system_reset_signature_ff <= (reg_wdata_i == dasr_pkg::RESET_SIGNATURE);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_clock_select_ff <= dasr_pkg::CLK_SEL_RESET;
    end else if (!link_enable_i) begin
      link_clock_select_ff <= dasr_pkg::CLK_SEL_RESET;
    end else if (wr_clk) begin
      link_clock_select_ff <= reg_wdata_i[1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      system_clock_request_ff <= 1'b0;
    end else if (!link_enable_i) begin
      system_clock_request_ff <= 1'b0;
    end else if (enable_rise) begin
      system_clock_request_ff <= 1'b1;
    end else if (wr_ctl) begin
      system_clock_request_ff <= reg_wdata_i[dasr_pkg::CTRL_SYSTEM_CLOCK_REQUEST_BIT];
    end
  end

  // Start pulse; the debugger must have filled RAM first
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      urow_start_ff <= 1'b0;
    end else begin
      urow_start_ff <= wr_ctl && reg_wdata_i[dasr_pkg::CTRL_UROW_DONE_BIT]
                       && user_row_write_key_active_ff;
    end
  end

  // Sticky reset flag; a new reset in the read cycle wins over the clear
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      system_reset_active_ff <= 1'b0;
    end else if (in_reset_s || system_reset_signature_ff) begin
      system_reset_active_ff <= 1'b1;
    end else if (rd_stat) begin
      system_reset_active_ff <= 1'b0;
    end
  end

  // One-hot CRC status; fail is reported if enabled but neither busy nor pass
  always_comb begin
    if (!crc_en_s) begin
      nxt_crc = dasr_pkg::CRC_OFF;
    end else if (crc_busy_s) begin
      nxt_crc = dasr_pkg::CRC_BUSY;
    end else if (crc_pass_s) begin
      nxt_crc = dasr_pkg::CRC_PASS;
    end else begin
      nxt_crc = dasr_pkg::CRC_FAIL;
    end
  end

  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_addr_i)
      dasr_pkg::KEY_STATUS_OFS: begin
        nxt_rdata[dasr_pkg::KEY_UROW_BIT] = user_row_write_key_active_ff;
        nxt_rdata[dasr_pkg::KEY_NVM_BIT] = memory_programming_key_active_ff;
        nxt_rdata[dasr_pkg::KEY_ERASE_BIT] = full_erase_key_active_ff;
      end
      dasr_pkg::RESET_REQ_OFS: begin
        nxt_rdata[0] = system_reset_signature_ff;
      end
      dasr_pkg::CLK_CTRL_OFS: begin
        nxt_rdata[1:0] = link_clock_select_ff;
      end
      dasr_pkg::SYS_CTRL_OFS: begin
        nxt_rdata[dasr_pkg::CTRL_SYSTEM_CLOCK_REQUEST_BIT] = system_clock_request_ff;
      end
      dasr_pkg::SYS_STATUS_OFS: begin
        nxt_rdata[dasr_pkg::ST_RST_BIT] = system_reset_active_ff
                                          || system_reset_signature_ff;
        nxt_rdata[dasr_pkg::ST_SLEEP_BIT] = asleep_s;
        nxt_rdata[dasr_pkg::ST_NVM_BIT] = prog_ready_s;
        nxt_rdata[dasr_pkg::ST_UROW_BIT] = urow_ready_s;
        nxt_rdata[dasr_pkg::ST_LOCK_BIT] = locked_s;
      end
      dasr_pkg::CRC_STATUS_OFS: begin
        nxt_rdata[2:0] = nxt_crc;
      end
      default: begin
        nxt_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Link clock tick; the base is one tick per sys clock at the 32 MHz setting
  always_comb begin
    case (link_clock_select_ff)
      dasr_pkg::CLK_SEL_32M: nxt_div_lim = dasr_pkg::DIV_32M;
      dasr_pkg::CLK_SEL_16M: nxt_div_lim = dasr_pkg::DIV_16M;
      dasr_pkg::CLK_SEL_8M: nxt_div_lim = dasr_pkg::DIV_8M;
      default: nxt_div_lim = dasr_pkg::DIV_4M;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_cnt_ff <= 4'h0;
      tick_ff <= 1'b0;
    end else if (div_cnt_ff + 4'h1 >= nxt_div_lim) begin
      div_cnt_ff <= 4'h0;
      tick_ff <= 1'b1;
    end else begin
      div_cnt_ff <= div_cnt_ff + 4'h1;
      tick_ff <= 1'b0;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign system_reset_o = system_reset_signature_ff;
  assign system_clock_request_o = system_clock_request_ff;
  assign user_row_programming_start_o = urow_start_ff;
  assign link_clock_select_o = link_clock_select_ff;
  assign link_clock_tick_o = tick_ff;
endmodule // dasr_regs

// ==== testbench/dasr_regs_props.sv ====
`timescale 1ns/1ns
module dasr_regs_props (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Link side
  input wire logic link_enable_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // System side
  input wire logic system_reset_o,
  input wire logic system_clock_request_o,
  input wire logic user_row_programming_start_o,
  input wire logic [1:0] link_clock_select_o,
  input wire logic link_clock_tick_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  logic wr_ok;
  logic done_wr;
  assign wr_ok = reg_wr_i && link_enable_i;
  assign done_wr = wr_ok && reg_addr_i == 4'hA && reg_wdata_i[1];
  sequence s_slow;
    link_clock_tick_o && link_clock_select_o == 2'h3
    ##1 (!link_clock_tick_o && link_clock_select_o == 2'h3) [*7];
  endsequence
  AST_RST_SET: assert property (wr_ok && reg_addr_i == 4'h8 && reg_wdata_i == 8'h59
    |=> system_reset_o) else $error("held reset not raised");
  AST_RST_CLR: assert property (wr_ok && reg_addr_i == 4'h8 && reg_wdata_i != 8'h59
    |=> !system_reset_o) else $error("held reset not released");
  AST_RD_RST: assert property (reg_rd_i && !reg_wr_i && reg_addr_i == 4'h8
    |=> reg_rdata_o == {7'h00, $past(system_reset_o)}) else $error("reset readback wrong");
  AST_SEL_WR: assert property (wr_ok && reg_addr_i == 4'h9
    |=> link_clock_select_o == $past(reg_wdata_i[1:0])) else $error("clock select wrong");
  AST_TICK_4M: assert property (s_slow |=> link_clock_tick_o)
    else $error("tick period wrong");
  AST_START_SRC: assert property (user_row_programming_start_o |-> $past(done_wr))
    else $error("start without write");
  AST_START_PULSE: assert property (user_row_programming_start_o
    |=> !user_row_programming_start_o) else $error("start too long");
  AST_SYSTEM_CLOCK_REQUEST_WR: assert property (wr_ok && reg_addr_i == 4'hA
    |=> system_clock_request_o == $past(reg_wdata_i[0])) else $error("clock request wrong");
  AST_SYSTEM_CLOCK_REQUEST_ON: assert property ($rose(link_enable_i)
    |-> ##[1:2] system_clock_request_o) else $error("clock request not set");
  AST_DISABLE: assert property (!link_enable_i ##1 !link_enable_i
    |-> !system_clock_request_o && !system_reset_o && link_clock_select_o == 2'h3)
    else $error("disable state wrong");
  cover property (s_slow ##1 link_clock_tick_o);
  cover property (user_row_programming_start_o);
  cover property (system_reset_o && reg_rd_i);
endmodule // dasr_regs_props

// ==== testbench/dasr_debugger.sv ====
`timescale 1ns/1ns
module dasr_debugger (
  // Clock
  input wire logic sys_clk_i,
  // Access-layer port
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [3:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 4'h0;
    reg_wdata_o = 8'h00;
  end
  // Idle address and data are inverted so nothing stale looks valid
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1 d = reg_rdata_i;
  endtask
  // Faster clocks only with the top brown-out level; unused bits set on purpose
  task automatic sel_clk(input logic [1:0] s, input logic bod_top);
    if (bod_top || s == 2'h3) wr(4'h9, {6'h3F, s});
  endtask
  // User-row data assumed already in RAM
  task automatic urow_finish();
    wr(4'hA, 8'h03);
  endtask
  task automatic prog_finish();
    wr(4'h8, 8'h59);
    wr(4'h8, 8'h00);
  endtask
endmodule // dasr_debugger

// ==== testbench/dasr_regs_tb.sv ====
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module dasr_regs_tb;
  logic sys_clk_i, rstn_i, link_enable_i, user_row_key_set_i, mem_prog_key_set_i;
  logic erase_key_set_i, sys_in_reset_i, sys_asleep_i, mem_prog_ready_i, user_row_ready_i;
  logic lock_bits_set_i, mem_prog_done_i, erase_done_i, crc_enabled_i, crc_busy_i, crc_pass_i;
  logic reg_wr_i, reg_rd_i, system_reset_o, system_clock_request_o;
  logic user_row_programming_start_o, link_clock_tick_o;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, d;
  logic [1:0] link_clock_select_o;
  int failures = 0;
  int checks_done = 0;
  dasr_regs i_dasr_regs (.sys_clk_i, .rstn_i, .link_enable_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .user_row_key_set_i, .mem_prog_key_set_i,
    .erase_key_set_i, .sys_in_reset_i, .sys_asleep_i, .mem_prog_ready_i, .user_row_ready_i,
    .lock_bits_set_i, .mem_prog_done_i, .erase_done_i, .crc_enabled_i, .crc_busy_i,
    .crc_pass_i, .system_reset_o, .system_clock_request_o, .user_row_programming_start_o,
    .link_clock_select_o, .link_clock_tick_o);
  dasr_debugger i_dasr_debugger (.sys_clk_i, .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic sync_wait();
    repeat (8) @(posedge sys_clk_i);
  endtask
  task automatic stop_test();
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic t_regs();
    logic [7:0] exp_v [7] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h01, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) begin
      i_dasr_debugger.rd(4'(7 + i), d);
      `CHK(d, exp_v[i]);
    end
  endtask
  task automatic t_system_clock_request();
    @(posedge sys_clk_i) link_enable_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1 `CHK(system_clock_request_o, 1'b1);
    i_dasr_debugger.wr(4'hA, 8'h00);
    #1 `CHK(system_clock_request_o, 1'b0);
    i_dasr_debugger.wr(4'hA, 8'h01);
    #1 `CHK(system_clock_request_o, 1'b1);
  endtask
  task automatic t_reset_req();
    i_dasr_debugger.wr(4'h8, 8'h59);
    #1 `CHK(system_reset_o, 1'b1);
    i_dasr_debugger.rd(4'h8, d);
    `CHK(d, 8'h01);
    i_dasr_debugger.wr(4'h8, 8'h58);
    #1 `CHK(system_reset_o, 1'b0);
    i_dasr_debugger.rd(4'h8, d);
    `CHK(d, 8'h00);
  endtask
  task automatic t_clk();
    int n;
    for (int s = 0; s < 4; s++) begin
      i_dasr_debugger.sel_clk(2'(s), 1'b1);
      i_dasr_debugger.rd(4'h9, d);
      `CHK(d, 8'(s));
      @(negedge sys_clk_i);
      for (int w = 0; w < 20 && !link_clock_tick_o; w++) @(negedge sys_clk_i);
      n = 0;
      do begin
        @(negedge sys_clk_i);
        n++;
      end while (!link_clock_tick_o && n < 20);
      `CHK(n, 1 << s);
    end
    i_dasr_debugger.sel_clk(2'h3, 1'b0);
  endtask
  task automatic t_keys();
    @(posedge sys_clk_i);
    user_row_key_set_i <= 1'b1;
    mem_prog_key_set_i <= 1'b1;
    erase_key_set_i <= 1'b1;
    @(posedge sys_clk_i);
    user_row_key_set_i <= 1'b0;
    mem_prog_key_set_i <= 1'b0;
    erase_key_set_i <= 1'b0;
    i_dasr_debugger.rd(4'h7, d);
    `CHK(d, 8'h38);
    @(posedge sys_clk_i) mem_prog_done_i <= 1'b1;
    sync_wait();
    mem_prog_done_i <= 1'b0;
    erase_done_i <= 1'b1;
    sync_wait();
    erase_done_i <= 1'b0;
    i_dasr_debugger.rd(4'h7, d);
    `CHK(d, 8'h20);
    i_dasr_debugger.urow_finish();
    #1 `CHK(user_row_programming_start_o, 1'b1);
    @(posedge sys_clk_i);
    #1 `CHK(user_row_programming_start_o, 1'b0);
    i_dasr_debugger.wr(4'h7, 8'h20);
    i_dasr_debugger.rd(4'h7, d);
    `CHK(d, 8'h00);
    i_dasr_debugger.urow_finish();
    #1 `CHK(user_row_programming_start_o, 1'b0);
  endtask
  task automatic t_status();
    @(posedge sys_clk_i);
    sys_in_reset_i <= 1'b1;
    sys_asleep_i <= 1'b1;
    mem_prog_ready_i <= 1'b1;
    user_row_ready_i <= 1'b1;
    sync_wait();
    sys_in_reset_i <= 1'b0;
    i_dasr_debugger.rd(4'hB, d);
    `CHK(d, 8'h3D);
    sync_wait();
    i_dasr_debugger.rd(4'hB, d);
    `CHK(d, 8'h3D);
    i_dasr_debugger.rd(4'hB, d);
    `CHK(d, 8'h1D);
    @(posedge sys_clk_i);
    {sys_asleep_i, mem_prog_ready_i, user_row_ready_i, lock_bits_set_i} <= 4'h0;
    sync_wait();
    i_dasr_debugger.wr(4'h8, 8'h59);
    i_dasr_debugger.rd(4'hB, d);
    `CHK(d, 8'h20);
    i_dasr_debugger.prog_finish();
    i_dasr_debugger.rd(4'hB, d);
    `CHK(d, 8'h20);
    i_dasr_debugger.rd(4'hB, d);
    `CHK(d, 8'h00);
  endtask
  task automatic t_crc();
    logic [2:0] in_v [4] = '{3'h0, 3'h6, 3'h5, 3'h4};
    logic [7:0] exp_v [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i) {crc_enabled_i, crc_busy_i, crc_pass_i} <= in_v[i];
      sync_wait();
      i_dasr_debugger.rd(4'hC, d);
      `CHK(d, exp_v[i]);
    end
  endtask
  task automatic t_disable();
    @(posedge sys_clk_i) user_row_key_set_i <= 1'b1;
    @(posedge sys_clk_i) user_row_key_set_i <= 1'b0;
    i_dasr_debugger.wr(4'h8, 8'h59);
    i_dasr_debugger.sel_clk(2'h0, 1'b1);
    @(posedge sys_clk_i) link_enable_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1 `CHK({system_reset_o, system_clock_request_o}, 2'h0);
    `CHK(link_clock_select_o, 2'h3);
    i_dasr_debugger.rd(4'h7, d);
    `CHK(d, 8'h00);
  endtask
  initial begin
    {rstn_i, link_enable_i, user_row_key_set_i, mem_prog_key_set_i, erase_key_set_i} = 5'h00;
    {sys_in_reset_i, sys_asleep_i, mem_prog_ready_i, user_row_ready_i} = 4'h0;
    {mem_prog_done_i, erase_done_i, crc_enabled_i, crc_busy_i, crc_pass_i} = 5'h00;
    lock_bits_set_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    sync_wait();
    t_regs();
    t_system_clock_request();
    t_reset_req();
    t_clk();
    t_keys();
    t_status();
    t_crc();
    t_disable();
    stop_test();
  end
  // Whole run needs about 220 cycles
  initial begin
    #100000;
    failures++;
    stop_test();
  end
endmodule // dasr_regs_tb
bind dasr_regs dasr_regs_props i_dasr_regs_props (.sys_clk_i, .rstn_i, .link_enable_i,
  .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .system_reset_o,
  .system_clock_request_o, .user_row_programming_start_o, .link_clock_select_o,
  .link_clock_tick_o);
